// >>> verilog/crf_core.sv
// CPU general register file, program counter and condition codes
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"
//////////////////////////////////////////////////////////////////////////
module crf_core (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	input  wire crf_pkg::crf_wr_t  wr_i,
	input  wire logic [2:0]        rd_idx_i,
	input  wire crf_pkg::crf_size_t rd_size_i,
	input  wire logic [2:0]        addr_idx_i,
	input  wire logic [2:0]        bit_sel_i,
	input  wire logic              sp_wr_i,
	input  wire logic [15:0]       sp_data_i,
	input  wire logic              pc_wr_i,
	input  wire logic [15:0]       pc_data_i,
	input  wire logic              vector_valid_i,
	input  wire crf_pkg::crf_alu_t alu_i,
	input  wire crf_pkg::crf_ccop_t cc_op_i,
	input  wire logic [7:0]        cc_data_i,
	input  wire logic              exc_start_i,
	output logic [15:0]            rd_data_o,
	output logic [15:0]            addr_o,
	output logic [15:0]            sp_o,
	output logic [15:0]            pc_o,
	output logic [7:0]             ccr_o,
	output logic                   irq_masked_o,
	output crf_pkg::crf_br_t       br_flags_o,
	output logic                   sel_bit_o,
	output logic                   half_carry_o,
	output logic                   vector_fetch_o
);
	import crf_pkg::*;

	typedef enum logic [1:0] {
		CRF_ST_VECTOR = 2'h0,
		CRF_ST_RUN    = 2'h1
	} crf_state_t;

	logic        rst_s1;          // Reset release stage one
	logic        rst_s2;          // Reset release stage two
	logic [7:0]  hi_q [0:7];      // Upper byte halves
	logic [7:0]  lo_q [0:7];      // Lower byte halves
	logic [15:0] pc;              // Program counter, bit 0 held zero
	logic [7:0]  condition_code_register;             // Condition code register
	logic [7:0]  alu_ccr;         // Flags after an ALU result
	logic [7:0]  next_ccr;        // Condition codes for next edge
	crf_state_t  state;           // Reset vector fetch state
	crf_state_t  next_state;      // Next state
	logic [7:0]  hi_seen;         // Upper half written since reset
	logic [7:0]  lo_seen;         // Lower half written since reset

	// Word read of one register pair
	function automatic logic [15:0] word_of(input logic [2:0] i,
			input logic [7:0] h, input logic [7:0] l);
		word_of = {h, l};
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Reset release; assertion is asynchronous, release is clocked
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// General registers carry no reset: contents undefined
	always_ff @(posedge sys_clk_i) begin
		if (wr_i.en) begin
			case (wr_i.size)
				// Word write fills both halves, MSB at 15
				CRF_SZ_WORD: begin
					hi_q[wr_i.idx] <= wr_i.data[15:8];
					lo_q[wr_i.idx] <= wr_i.data[7:0];
				end
				// Byte data in the low lane; other half kept
				CRF_SZ_HIGH: hi_q[wr_i.idx] <= wr_i.data[7:0];
				CRF_SZ_LOW: lo_q[wr_i.idx] <= wr_i.data[7:0];
				default: begin
					lo_q[wr_i.idx] <= lo_q[wr_i.idx];
				end
			endcase
		end
		// Implicit stack pointer update wins last
		if (sp_wr_i) begin
			hi_q[`CRF_SP_INDEX] <= sp_data_i[15:8];
			lo_q[`CRF_SP_INDEX] <= sp_data_i[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Written-half tracking for the checks only; the halves themselves
	// stay without reset, so a check must not look at a half that no
	// write has defined yet
	always_ff @(posedge sys_clk_i or negedge rst_s2) begin
		if (!rst_s2) begin
			hi_seen <= 8'h00;
			lo_seen <= 8'h00;
		end else begin
			// Word and upper-half writes define the upper half
			if (wr_i.en && wr_i.size != CRF_SZ_LOW)
				hi_seen[wr_i.idx] <= 1'b1;
			// Word and lower-half writes define the lower half
			if (wr_i.en && wr_i.size != CRF_SZ_HIGH)
				lo_seen[wr_i.idx] <= 1'b1;
			// Implicit stack write defines the whole eighth word
			if (sp_wr_i) begin
				hi_seen[`CRF_SP_INDEX] <= 1'b1;
				lo_seen[`CRF_SP_INDEX] <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Registered read ports
	always_ff @(posedge sys_clk_i) begin
		// Data read: word or one byte half
		case (rd_size_i)
			CRF_SZ_WORD:
				rd_data_o <= word_of(rd_idx_i, hi_q[rd_idx_i],
					lo_q[rd_idx_i]);
			CRF_SZ_HIGH: rd_data_o <= {8'h00, hi_q[rd_idx_i]};
			CRF_SZ_LOW: rd_data_o <= {8'h00, lo_q[rd_idx_i]};
			default: rd_data_o <= 16'h0000;
		endcase
		// Address read is never narrowed
		addr_o <= word_of(addr_idx_i, hi_q[addr_idx_i], lo_q[addr_idx_i]);
		// Stack pointer is the eighth word
		sp_o <= word_of(`CRF_SP_INDEX, hi_q[`CRF_SP_INDEX],
			lo_q[`CRF_SP_INDEX]);
		// Bit selection within a byte operand
		sel_bit_o <= lo_q[rd_idx_i][bit_sel_i];
	end

	//////////////////////////////////////////////////////////////////////
	// Reset sequence: wait for the vector word
	always_comb begin
		next_state = state;
		case (state)
			CRF_ST_VECTOR: if (vector_valid_i) next_state = CRF_ST_RUN;
			CRF_ST_RUN: next_state = CRF_ST_RUN;
			default: next_state = CRF_ST_VECTOR;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_s2) begin
		if (!rst_s2) begin
			state <= CRF_ST_VECTOR;
			vector_fetch_o <= 1'b1;
		end else begin
			state <= next_state;
			vector_fetch_o <= (next_state == CRF_ST_VECTOR);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Program counter; the fetch is word-wide so bit 0 stays clear
	always_ff @(posedge sys_clk_i or negedge rst_s2) begin
		if (!rst_s2) begin
			pc <= `CRF_RESET_VECTOR;
		end else if (state == CRF_ST_VECTOR) begin
			if (vector_valid_i)
				pc <= {pc_data_i[15:1], 1'b0};
		end else if (pc_wr_i) begin
			pc <= {pc_data_i[15:1], 1'b0};
		end
	end
	assign pc_o = pc;

	//////////////////////////////////////////////////////////////////////
	// Flag arithmetic kept apart so it can be reused by other users
	crf_flag_calc u_flags (
		.alu_i (alu_i),
		.ccr_i (condition_code_register),
		.ccr_o (alu_ccr)
	);

	// Software edits take priority over ALU flags
	always_comb begin
		case (cc_op_i)
			CRF_CC_LOAD: next_ccr = cc_data_i;
			CRF_CC_AND: next_ccr = condition_code_register & cc_data_i;
			CRF_CC_OR: next_ccr = condition_code_register | cc_data_i;
			CRF_CC_XOR: next_ccr = condition_code_register ^ cc_data_i;
			default: next_ccr = alu_ccr;
		endcase
		// User bits 6 and 4 change only by software
		if (cc_op_i == CRF_CC_KEEP) begin
			next_ccr[`CRF_CC_U6] = condition_code_register[`CRF_CC_U6];
			next_ccr[`CRF_CC_U4] = condition_code_register[`CRF_CC_U4];
		end
		// Exception entry masks interrupts, winning over edits
		if (exc_start_i)
			next_ccr[`CRF_CC_I] = 1'b1;
	end

	// Reset loads the whole register: mask bit set, all other bits clear
	always_ff @(posedge sys_clk_i or negedge rst_s2) begin
		if (!rst_s2)
			condition_code_register <= `CRF_RESET_CCR;
		else
			condition_code_register <= next_ccr;
	end
	assign ccr_o = condition_code_register;
	assign irq_masked_o = condition_code_register[`CRF_CC_I];
	// Branch flags straight from the register
	assign br_flags_o = '{n: condition_code_register[`CRF_CC_N], z: condition_code_register[`CRF_CC_Z],
		v: condition_code_register[`CRF_CC_V], c: condition_code_register[`CRF_CC_C]};
	// Half-carry offered to decimal adjust
	assign half_carry_o = condition_code_register[`CRF_CC_H];

	//////////////////////////////////////////////////////////////////////
	// Checks
	pc_even_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		pc[0] == 1'b0) else $error("pc bit 0 set");

	exc_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		exc_start_i |=> condition_code_register[`CRF_CC_I]) else $error("mask not set");

	user_bits_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_s2)
		cc_op_i == CRF_CC_KEEP |=> $stable({condition_code_register[`CRF_CC_U6],
		condition_code_register[`CRF_CC_U4]})) else $error("user bit moved");

	cc_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		cc_op_i == CRF_CC_LOAD && !exc_start_i |=> condition_code_register == $past(cc_data_i))
		else $error("ccr load lost");

	cc_and_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		cc_op_i == CRF_CC_AND && !exc_start_i
		|=> condition_code_register == ($past(condition_code_register) & $past(cc_data_i)))
		else $error("ccr and wrong");

	zero_flag_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_s2)
		cc_op_i == CRF_CC_KEEP && alu_i.op == CRF_OP_ADD && alu_i.word
		&& alu_i.res == 16'h0000 |=> condition_code_register[`CRF_CC_Z])
		else $error("zero flag");

	neg_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		cc_op_i == CRF_CC_KEEP && alu_i.op == CRF_OP_SUB && !alu_i.word
		|=> condition_code_register[`CRF_CC_N] == $past(alu_i.res[7]))
		else $error("negative flag");

	addr_word_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_s2)
		!wr_i.en && !sp_wr_i && hi_seen[addr_idx_i] && lo_seen[addr_idx_i]
		|=> addr_o == {hi_q[$past(addr_idx_i)],
		lo_q[$past(addr_idx_i)]}) else $error("addr narrowed");

	sequence vec_wait_s;
		state == CRF_ST_VECTOR && vector_valid_i;
	endsequence
	vec_load_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_s2)
		vec_wait_s |=> pc == {$past(pc_data_i[15:1]), 1'b0} && !vector_fetch_o)
		else $error("vector not loaded");

	// Stack pointer view follows the eighth word
	sp_word_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		!wr_i.en && !sp_wr_i && hi_seen[`CRF_SP_INDEX]
		&& lo_seen[`CRF_SP_INDEX]
		|=> sp_o == {hi_q[`CRF_SP_INDEX], lo_q[`CRF_SP_INDEX]})
		else $error("sp view wrong");

	// A byte read never shows bits in the upper lane
	byte_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		rd_size_i != CRF_SZ_WORD |=> rd_data_o[15:8] == 8'h00)
		else $error("byte read wide");

	// While the vector is awaited, software loads are refused
	pc_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_s2)
		state == CRF_ST_VECTOR && !vector_valid_i |=> pc == $past(pc))
		else $error("pc moved early");
endmodule
`default_nettype wire

// >>> verilog/crf_cfg.svh
// Constants for the CPU register file and condition code block
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
`define CRF_CC_I          7
`define CRF_CC_U6         6
`define CRF_CC_H          5
`define CRF_CC_U4         4
`define CRF_CC_N          3
`define CRF_CC_Z          2
`define CRF_CC_V          1
`define CRF_CC_C          0
`define CRF_RESET_VECTOR  16'h0000
`define CRF_SP_INDEX      3'h7
`define CRF_BYTE_HC_BIT   4
`define CRF_WORD_HC_BIT   12
`define CRF_RESET_CCR     8'h80
`endif

// >>> verilog/crf_pkg.sv
// Types for the CPU register file and condition code block
package crf_pkg;
	// Register operand width
	typedef enum logic [1:0] {
		CRF_SZ_WORD = 2'h0,
		CRF_SZ_HIGH = 2'h1,
		CRF_SZ_LOW  = 2'h2
	} crf_size_t;
	// Flag update source for one ALU result
	typedef enum logic [2:0] {
		CRF_OP_NONE  = 3'h0,
		CRF_OP_ADD   = 3'h1,
		CRF_OP_SUB   = 3'h3,
		CRF_OP_LOGIC = 3'h2,
		CRF_OP_SHIFT = 3'h6,
		CRF_OP_BIT   = 3'h7
	} crf_op_t;
	// Condition code edits by software
	typedef enum logic [2:0] {
		CRF_CC_KEEP = 3'h0,
		CRF_CC_LOAD = 3'h1,
		CRF_CC_AND  = 3'h3,
		CRF_CC_OR   = 3'h2,
		CRF_CC_XOR  = 3'h6
	} crf_ccop_t;
	// One register write
	typedef struct packed {
		logic        en;
		logic [2:0]  idx;
		crf_size_t   size;
		logic [15:0] data;
	} crf_wr_t;
	// One ALU result for flag update
	typedef struct packed {
		crf_op_t     op;
		logic        word;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] res;
		logic        cin;
		logic        cout;
		logic        bitval;
	} crf_alu_t;
	// Branch condition flags
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} crf_br_t;
endpackage

// >>> verilog/crf_flag_calc.sv
// Flag computation from one ALU result
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"
module crf_flag_calc (
	input  wire crf_pkg::crf_alu_t alu_i,
	input  wire logic [7:0]        ccr_i,
	output logic [7:0]             ccr_o
);
	import crf_pkg::*;
	logic [15:0] sa;      // Sign-aligned operand a
	logic [15:0] sb;      // Sign-aligned operand b
	logic [15:0] sr;      // Sign-aligned result
	logic        hc;      // Carry or borrow into the half-carry bit
	logic        ov;      // Signed overflow
	logic [16:0] tmp;     // Low-part sum for nibble carry

	// Flags follow the operand width; byte operands sit in bits 7:0
	always_comb begin
		ccr_o = ccr_i;
		sa = alu_i.word ? alu_i.a : {alu_i.a[7:0], 8'h00};
		sb = alu_i.word ? alu_i.b : {alu_i.b[7:0], 8'h00};
		sr = alu_i.word ? alu_i.res : {alu_i.res[7:0], 8'h00};
		tmp = 17'h00000;
		hc = 1'b0;
		if (alu_i.word) begin
			// Word operations only; carry out of bit 11
			// Word-sized flag path
			if (alu_i.op == CRF_OP_SUB)
				tmp = {5'h00, alu_i.a[11:0]} - {5'h00, alu_i.b[11:0]};
			else
				tmp = {5'h00, alu_i.a[11:0]} + {5'h00, alu_i.b[11:0]};
			hc = tmp[`CRF_WORD_HC_BIT];
		end else begin
			// Carry or borrow out of bit 3
			if (alu_i.op == CRF_OP_SUB)
				tmp = {13'h0000, alu_i.a[3:0]}
					- {13'h0000, alu_i.b[3:0]} - {16'h0000, alu_i.cin};
			else
				tmp = {13'h0000, alu_i.a[3:0]}
					+ {13'h0000, alu_i.b[3:0]} + {16'h0000, alu_i.cin};
			hc = tmp[`CRF_BYTE_HC_BIT];
		end
		// Signed overflow from operand and result signs
		if (alu_i.op == CRF_OP_SUB)
			ov = (sa[15] ^ sb[15]) & (sa[15] ^ sr[15]);
		else
			ov = ~(sa[15] ^ sb[15]) & (sa[15] ^ sr[15]);
		case (alu_i.op)
			CRF_OP_ADD, CRF_OP_SUB: begin
				ccr_o[`CRF_CC_H] = hc;
				ccr_o[`CRF_CC_N] = sr[15];
				ccr_o[`CRF_CC_Z] = (sr == 16'h0000);
				ccr_o[`CRF_CC_V] = ov;
				ccr_o[`CRF_CC_C] = alu_i.cout;
			end
			CRF_OP_LOGIC: begin
				// Logic results clear overflow, keep carry
				ccr_o[`CRF_CC_N] = sr[15];
				ccr_o[`CRF_CC_Z] = (sr == 16'h0000);
				ccr_o[`CRF_CC_V] = 1'b0;
			end
			CRF_OP_SHIFT: begin
				// Bit shifted out lands in carry
				ccr_o[`CRF_CC_N] = sr[15];
				ccr_o[`CRF_CC_Z] = (sr == 16'h0000);
				ccr_o[`CRF_CC_V] = 1'b0;
				ccr_o[`CRF_CC_C] = alu_i.cout;
			end
			CRF_OP_BIT: begin
				// Carry acts as the bit accumulator
				ccr_o[`CRF_CC_C] = alu_i.bitval;
			end
			default: begin
				ccr_o = ccr_i;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> tb/crf_vec_model.sv
// Model of the execution logic that hands the core its reset vector
`timescale 1ns/100ps
`default_nettype none
module crf_vec_model #(
	parameter logic [15:0] VECTOR = 16'h1235, // Word at the vector slot
	parameter int          LAT    = 0         // Extra edges before answer
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        vector_fetch_i,
	output logic             vector_valid_o,
	output logic [15:0]      vector_word_o
);
	int unsigned since_rel; // Edges seen since reset went away

	////////////////////////////////////////////////////////////////////////
	// Count edges; the core's reset copy needs two edges to clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			since_rel <= 0;
		end else if (since_rel < 1000) begin
			since_rel <= since_rel + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answer no earlier than the third edge, and hold until taken
	assign vector_valid_o = vector_fetch_i && (since_rel >= 2 + LAT);
	// Off the bus the word is inverted, so a stale value never looks valid
	assign vector_word_o = vector_valid_o ? VECTOR : ~VECTOR;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the register file and condition code block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import crf_pkg::*;
	logic        sys_clk_i   = 1'b0;      // 100 MHz clock
	logic        rst_b_i     = 1'b0;      // Reset, active low
	crf_wr_t     wr_i        = '0;        // Register write request
	logic [2:0]  rd_idx_i    = 3'h0;      // Data read select
	crf_size_t   rd_size_i   = CRF_SZ_WORD;
	logic [2:0]  addr_idx_i  = 3'h0;      // Address read select
	logic [2:0]  bit_sel_i   = 3'h0;      // Bit number select
	logic        sp_wr_i     = 1'b0;      // Implicit stack pointer write
	logic [15:0] sp_data_i   = 16'h0000;
	logic        pc_wr_i     = 1'b0;      // Program counter load
	logic [15:0] pc_req      = 16'h0000;  // Bench's own load value
	crf_alu_t    alu_i       = '0;        // Flag update source
	crf_ccop_t   cc_op_i     = CRF_CC_KEEP;
	logic [7:0]  cc_data_i   = 8'h00;
	logic        exc_start_i = 1'b0;      // Exception entry pulse
	logic        vec_valid;               // Partner presents vector
	logic [15:0] vec_word;
	logic [15:0] pc_data_i;               // Shared load bus into the core
	logic [15:0] rd_data_o, addr_o, sp_o, pc_o;
	logic [7:0]  ccr_o;
	logic        irq_masked_o, sel_bit_o, half_carry_o, vector_fetch_o;
	crf_br_t     br_flags_o;
	int          errors      = 0;         // Mismatches seen
	int          check_count = 0;         // Comparisons made
	int          n;

	always #5 sys_clk_i = ~sys_clk_i;
	// Vector word wins the load bus while the partner offers it
	assign pc_data_i = vec_valid ? vec_word : pc_req;

	crf_vec_model u_vec (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.vector_fetch_i(vector_fetch_o), .vector_valid_o(vec_valid),
		.vector_word_o(vec_word));

	crf_core u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i),
		.rd_idx_i(rd_idx_i), .rd_size_i(rd_size_i), .addr_idx_i(addr_idx_i),
		.bit_sel_i(bit_sel_i), .sp_wr_i(sp_wr_i), .sp_data_i(sp_data_i),
		.pc_wr_i(pc_wr_i), .pc_data_i(pc_data_i),
		.vector_valid_i(vec_valid), .alu_i(alu_i), .cc_op_i(cc_op_i),
		.cc_data_i(cc_data_i), .exc_start_i(exc_start_i),
		.rd_data_o(rd_data_o), .addr_o(addr_o), .sp_o(sp_o), .pc_o(pc_o),
		.ccr_o(ccr_o), .irq_masked_o(irq_masked_o), .br_flags_o(br_flags_o),
		.sel_bit_o(sel_bit_o), .half_carry_o(half_carry_o),
		.vector_fetch_o(vector_fetch_o));

	////////////////////////////////////////////////////////////////////////
	// Verdict in one place; also the exit for an exhausted wait
	task automatic report_and_stop();
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Narrow results are zero-extended by the caller
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One write, held for exactly one taking edge
	task automatic wr(input logic [2:0] i, input crf_size_t s,
		input logic [15:0] d);
		@(posedge sys_clk_i);
		wr_i <= '{1'b1, i, s, d};
		@(posedge sys_clk_i);
		wr_i.en <= 1'b0;
	endtask

	// Data read plus address read of the same register, one cycle late
	task automatic rd(input logic [2:0] i, input crf_size_t s,
		input logic [15:0] e, input logic [15:0] full);
		@(posedge sys_clk_i);
		rd_idx_i <= i;
		rd_size_i <= s;
		addr_idx_i <= i;
		@(posedge sys_clk_i);
		#1;
		chk("rd_data_o", e, rd_data_o);
		chk("addr_o", full, addr_o);
	endtask

	// Software edit of the condition codes
	task automatic cc(input crf_ccop_t op, input logic [7:0] d,
		input logic [7:0] e);
		@(posedge sys_clk_i);
		cc_op_i <= op;
		cc_data_i <= d;
		@(posedge sys_clk_i);
		cc_op_i <= CRF_CC_KEEP;
		#1;
		chk("ccr_o", {8'h00, e}, {8'h00, ccr_o});
		@(posedge sys_clk_i);
		#1;
		chk("irq_masked_o", {15'h0, e[7]}, {15'h0, irq_masked_o});
	endtask

	// One ALU result; flag views are checked a further edge on
	task automatic alu(input crf_op_t op, input logic w,
		input logic [15:0] a, input logic [15:0] b, input logic [15:0] r,
		input logic co, input logic [7:0] e);
		@(posedge sys_clk_i);
		alu_i <= '{op, w, a, b, r, 1'b0, co, 1'b0};
		@(posedge sys_clk_i);
		alu_i.op <= CRF_OP_NONE;
		#1;
		chk("ccr_o", {8'h00, e}, {8'h00, ccr_o});
		@(posedge sys_clk_i);
		#1;
		chk("br_flags_o", {12'h0, e[3:0]}, {12'h0, br_flags_o});
		chk("half_carry_o", {15'h0, e[5]}, {15'h0, half_carry_o});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk_i);
		#1;
		chk("ccr_o", 16'h0080, {8'h00, ccr_o});
		chk("pc_o", 16'h0000, pc_o);
		chk("vector_fetch_o", 16'h1, {15'h0, vector_fetch_o});
		repeat (5) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		// Bounded wait for the vector to be taken
		n = 0;
		while (vector_fetch_o !== 1'b0 && n < 20) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 20) begin
			errors++;
			report_and_stop();
		end
		#1;
		chk("pc_o", 16'h1234, pc_o);
		@(posedge sys_clk_i);
		pc_wr_i <= 1'b1;
		pc_req <= 16'hABCD;
		@(posedge sys_clk_i);
		pc_wr_i <= 1'b0;
		#1;
		chk("pc_o", 16'hABCC, pc_o);
		// Eight words, then each read back as a word
		for (int i = 0; i < 8; i++) wr(i[2:0], CRF_SZ_WORD, 16'h1111 * (i + 1));
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], CRF_SZ_WORD, 16'h1111 * (i + 1), 16'h1111 * (i + 1));
		end
		// Byte halves: upper data bits ignored, other half kept
		wr(3'h2, CRF_SZ_HIGH, 16'h55AB);
		rd(3'h2, CRF_SZ_WORD, 16'hAB33, 16'hAB33);
		wr(3'h2, CRF_SZ_LOW, 16'h66CD);
		rd(3'h2, CRF_SZ_HIGH, 16'h00AB, 16'hABCD);
		rd(3'h2, CRF_SZ_LOW, 16'h00CD, 16'hABCD);
		rd(3'h3, CRF_SZ_WORD, 16'h4444, 16'h4444);
		chk("sp_o", 16'h8888, sp_o);
		// Implicit stack write beats a same-edge write to register 7
		@(posedge sys_clk_i);
		sp_wr_i <= 1'b1;
		sp_data_i <= 16'hFF00;
		wr_i <= '{1'b1, 3'h7, CRF_SZ_WORD, 16'h0123};
		@(posedge sys_clk_i);
		sp_wr_i <= 1'b0;
		wr_i.en <= 1'b0;
		rd(3'h7, CRF_SZ_WORD, 16'hFF00, 16'hFF00);
		chk("sp_o", 16'hFF00, sp_o);
		// Every bit position of a byte operand
		wr(3'h1, CRF_SZ_LOW, 16'h00A5);
		for (int b = 0; b < 8; b++) begin
			@(posedge sys_clk_i);
			rd_idx_i <= 3'h1;
			bit_sel_i <= b[2:0];
			@(posedge sys_clk_i);
			#1;
			chk("sel_bit_o", {8'h00, (8'hA5 >> b) & 8'h01}, {15'h0, sel_bit_o});
		end
		// Software edits of the condition codes
		cc(CRF_CC_LOAD, 8'h50, 8'h50);
		cc(CRF_CC_OR, 8'h81, 8'hD1);
		cc(CRF_CC_AND, 8'hEF, 8'hC1);
		cc(CRF_CC_XOR, 8'h3F, 8'hFE);
		cc(CRF_CC_LOAD, 8'h50, 8'h50);
		@(posedge sys_clk_i);
		exc_start_i <= 1'b1;
		@(posedge sys_clk_i);
		exc_start_i <= 1'b0;
		#1;
		chk("ccr_o", 16'h00D0, {8'h00, ccr_o});
		// Flag updates; user bits and mask must ride through
		alu(CRF_OP_ADD, 1'b0, 16'h000F, 16'h0001, 16'h0010, 1'b0, 8'hF0);
		alu(CRF_OP_ADD, 1'b0, 16'h007F, 16'h0001, 16'h0080, 1'b0, 8'hFA);
		alu(CRF_OP_ADD, 1'b0, 16'h00FF, 16'h0001, 16'h0000, 1'b1, 8'hF5);
		alu(CRF_OP_ADD, 1'b0, 16'h0001, 16'h0001, 16'h0002, 1'b0, 8'hD0);
		alu(CRF_OP_ADD, 1'b1, 16'h0FFF, 16'h0001, 16'h1000, 1'b0, 8'hF0);
		alu(CRF_OP_SUB, 1'b0, 16'h0010, 16'h0001, 16'h000F, 1'b0, 8'hF0);
		alu(CRF_OP_SHIFT, 1'b0, 16'h0002, 16'h0000, 16'h0001, 1'b1, 8'hF1);
		report_and_stop();
	end
endmodule
`default_nettype wire
